// file: design/csi_pkg.sv
// Purpose: Shared constants and types of the control space interpreter.
// Assumes: One 100 MHz clock; every port except the interrupt line is
// synchronous to it.
// Notes: Program words are three 16-bit fields: opcode, op1, op2.
// Summary of operation
// RL1: Bus access completion sets status bit 10; reading read data clears it.
// RL2: Status bit 7 shows interrupt line; bus access waits until vector read.
// RL3: Status bits 0 to 6 mirror the matching adapter control bits.
// RL4: Host writes buffer only below E000; peripheral registers only via program.
// RL5: On entry capture status, set DMA and bus masks, disallow interrupts.
// RL6: Control writes go to a shadow, applied at end; else captured value restored.
// RL7: Before the first command, a pending interrupt gets its vector read.
// RL8: At completion send Device End, plus attention if an interrupt pends.
// RL9: Accumulator holds the latest peripheral, status or vector read.
// RL10: Pointer starts at zero, steps by one, or loads a taken jump target.
// RL11: Count instructions; beyond the limit stop, flag error, send Unit Check.
// RL12: Limit defaults to 5000; opcode 10 sets it; zero disables the check.
// RL13: Opcode 0 ends, 1 records control data, 2 reads status to target.
// RL14: Opcode 3 writes an immediate word, opcode 11 only its low byte.
// RL15: Opcode 4 copies source to target and accumulator; 12 loads accumulator.
// RL16: Opcode 5 jumps when accumulator AND mask is zero.
// RL17: Opcode 6 jumps when all masked accumulator bits are set.
// RL18: Opcode 7 jumps always; opcode 9 jumps when accumulator equals operand.
// RL19: Opcode 8 reads the vector into target and accumulator.
// RL20: Opcode 13 selects word mode on flag 1, byte-swapped mode on 0.
// RL21: Opcode 14 sends an attention carrying its data operand.
// RL22: Host start address FFFF in the upper half selects the start offset.
// RL23: A vector read returns the vector and clears the pending interrupt.
// RL24: Undefined opcodes end the program and report an error like the limit.
package csi_pkg;
	localparam int IP_W = 6;
	localparam int PROG_DEPTH = 64;
	localparam int ST_INTERRUPT_LINE = 7;
	localparam int ST_DONE = 10;
	localparam logic [15:0] LIMIT_RST = 16'h1388;
	localparam logic [15:0] CTL_RST = 16'h0000;
	localparam logic [15:0] CTL_MASKS = 16'h003E;
	localparam logic [15:0] CTL_ALLOW = 16'h0040;
	localparam logic [15:0] BUF_TOP = 16'hDFFF;
	localparam logic [15:0] START_KEY = 16'hFFFF;
	localparam logic [15:0] INTERRUPT_LINE_ATTN_DATA = 16'h0000;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [11:0] OPC_HI_ZERO = 12'h000;

	typedef enum logic [3:0] {
		OP_END = 4'h0,
		OP_WRITE_CONTROL = 4'h1,
		OP_READ_STATUS = 4'h2,
		OP_WRITE_IMMEDIATE_WORD = 4'h3,
		OP_MOVE = 4'h4,
		OP_BRANCH_IF_MASKED_ZERO = 4'h5,
		OP_BRANCH_IF_ALL_MASKED_SET = 4'h6,
		OP_JUMP = 4'h7,
		OP_READ_VECTOR = 4'h8,
		OP_BRANCH_IF_EQUAL = 4'h9,
		OP_SET_LIMIT = 4'hA,
		OP_WRITE_IMMEDIATE_BYTE = 4'hB,
		OP_LOAD = 4'hC,
		OP_WRITE_WIDTH_MODE = 4'hD,
		OP_HOST_ATTENTION = 4'hE,
		OP_UNDEFINED = 4'hF
	} csi_opc_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_CAPT = 4'h1,
		S_FETCH = 4'h2,
		S_DECODE = 4'h3,
		S_BUS = 4'h4,
		S_ACK = 4'h5,
		S_VEC = 4'h6,
		S_VWAIT = 4'h7,
		S_FINISH = 4'h8
	} csi_state_t;

	typedef struct packed {
		logic [15:0] opc;
		logic [15:0] op1;
		logic [15:0] op2;
	} csi_instr_t;

	typedef struct packed {
		logic req;
		logic we;
		logic bsel;
		logic [15:0] addr;
		logic [15:0] wdata;
	} csi_pio_t;
endpackage : csi_pkg

// file: design/csi_prog_mem.sv
// Purpose: Program store of the control space interpreter.
// Assumes: Host writes and interpreter reads share the system clock.
// Notes: Read data come from a register one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module csi_prog_mem (
	input wire logic sys_clk_i,
	input wire logic wr_en_i,
	input wire logic [csi_pkg::IP_W-1:0] wr_addr_i,
	input wire csi_pkg::csi_instr_t wr_data_i,
	input wire logic [csi_pkg::IP_W-1:0] rd_addr_i,
	output csi_pkg::csi_instr_t rd_data_o
);
	csi_pkg::csi_instr_t mem [csi_pkg::PROG_DEPTH];

	always_ff @(posedge sys_clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end
endmodule : csi_prog_mem
`default_nettype wire

// file: design/csi_interp.sv
// Purpose: Control space interpreter with adapter status and control.
// Assumes: Peripheral bus answers on this clock; interrupt line is a pin.
// Notes: Buffer memory and device registers share one 16-bit space.
`timescale 1ns/1ps
`default_nettype none
module csi_interp (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic prog_wr_i,
	input wire logic [csi_pkg::IP_W-1:0] prog_addr_i,
	input wire csi_pkg::csi_instr_t prog_data_i,
	input wire logic buf_wr_i,
	input wire logic [15:0] buf_addr_i,
	input wire logic [15:0] buf_data_i,
	input wire logic start_i,
	input wire logic [31:0] start_addr_i,
	output csi_pkg::csi_pio_t pio_o,
	input wire logic pio_done_i,
	input wire logic [15:0] pio_rdata_i,
	input wire logic interrupt_line_i,
	output logic vec_rd_o,
	input wire logic vec_ack_i,
	input wire logic [15:0] vec_data_i,
	output logic [15:0] adapter_control_o,
	output logic [15:0] adapter_status_o,
	output logic [15:0] accumulator_o,
	output logic busy_o,
	output logic buf_refused_o,
	output logic dev_end_o,
	output logic unit_check_o,
	output logic attn_o,
	output logic [15:0] attn_data_o,
	output logic local_err_o
);
	csi_pkg::csi_instr_t ins;
	csi_pkg::csi_state_t state_ff, nxt_state;
	csi_pkg::csi_pio_t pio_ff, nxt_pio;
	logic [csi_pkg::IP_W-1:0] ip_ff, nxt_ip;
	logic [15:0] count_ff, nxt_count, limit_ff, nxt_limit;
	logic [15:0] acc_ff, nxt_acc, ctl_ff, nxt_ctl, saved_ff, nxt_saved;
	logic [15:0] shadow_ff, nxt_shadow, stat_ff, status;
	logic [15:0] addr_ff, nxt_addr, wdata_ff, nxt_wdata, tgt_ff, nxt_tgt;
	logic [15:0] attn_data_ff, nxt_attn_data;
	logic shadow_vld_ff, nxt_shadow_vld, word_mode_ff, nxt_word_mode;
	logic err_ff, nxt_err, done_ff, nxt_done, rd_ff, nxt_rd;
	logic bsel_ff, nxt_bsel, wr_pend_ff, nxt_wr_pend, host_ff, nxt_host;
	logic vchk_ff, nxt_vchk, vec_rd_ff, nxt_vec_rd, refused_ff, nxt_refused;
	logic dev_end_ff, nxt_dev_end, uc_ff, nxt_uc, attn_ff, nxt_attn;
	logic lerr_ff, nxt_lerr, busy_ff, nxt_busy;
	logic int_m1_ff, int_m2_ff, int_m3_ff, interrupt_line_s_ff, nxt_interrupt_line_s;
	logic [15:0] masked;

	csi_prog_mem u_mem (
		.sys_clk_i(sys_clk_i),
		.wr_en_i(prog_wr_i),
		.wr_addr_i(prog_addr_i),
		.wr_data_i(prog_data_i),
		.rd_addr_i(ip_ff),
		.rd_data_o(ins)
	);

	// The interrupt line counts as changed once stages two and three agree.
	always_comb begin
		nxt_interrupt_line_s = interrupt_line_s_ff;
		if (int_m2_ff == int_m3_ff) begin
			nxt_interrupt_line_s = int_m3_ff;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			int_m1_ff <= 1'b0;
			int_m2_ff <= 1'b0;
			int_m3_ff <= 1'b0;
			interrupt_line_s_ff <= 1'b0;
		end else begin
			int_m1_ff <= interrupt_line_i;
			int_m2_ff <= int_m1_ff;
			int_m3_ff <= int_m2_ff;
			interrupt_line_s_ff <= nxt_interrupt_line_s;
		end
	end

	// Self-test bits 8 and 9 read as zero.
	assign status = {5'h00, done_ff, 2'b00, interrupt_line_s_ff, ctl_ff[6:0]}; // [RL2] [RL3]
	assign masked = acc_ff & ins.op2;

	always_comb begin
		nxt_state = state_ff;
		nxt_pio = pio_ff;
		nxt_pio.req = 1'b0;
		nxt_ip = ip_ff;
		nxt_count = count_ff;
		nxt_limit = limit_ff;
		nxt_acc = acc_ff;
		nxt_ctl = ctl_ff;
		nxt_saved = saved_ff;
		nxt_shadow = shadow_ff;
		nxt_shadow_vld = shadow_vld_ff;
		nxt_word_mode = word_mode_ff;
		nxt_err = err_ff;
		nxt_done = done_ff;
		nxt_rd = rd_ff;
		nxt_bsel = bsel_ff;
		nxt_wr_pend = wr_pend_ff;
		nxt_host = host_ff;
		nxt_vchk = vchk_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_tgt = tgt_ff;
		nxt_vec_rd = 1'b0;
		nxt_refused = 1'b0;
		nxt_dev_end = 1'b0;
		nxt_uc = uc_ff;
		nxt_attn = 1'b0;
		nxt_attn_data = attn_data_ff;
		nxt_lerr = 1'b0;
		unique case (state_ff)
			csi_pkg::S_IDLE: begin
				if (start_i) begin
					// A keyed start address picks the entry offset.
					if (start_addr_i[31:16] == csi_pkg::START_KEY) begin // [RL22]
						nxt_ip = start_addr_i[csi_pkg::IP_W-1:0];
					end else begin
						nxt_ip = '0; // [RL10]
					end
					nxt_count = csi_pkg::ZERO16;
					nxt_err = 1'b0;
					nxt_shadow_vld = 1'b0;
					nxt_word_mode = 1'b1;
					nxt_state = csi_pkg::S_CAPT;
				end else if (buf_wr_i) begin
					if (buf_addr_i <= csi_pkg::BUF_TOP) begin // [RL4]
						nxt_host = 1'b1;
						nxt_rd = 1'b0;
						nxt_bsel = 1'b0;
						nxt_wr_pend = 1'b0;
						nxt_addr = buf_addr_i;
						nxt_wdata = buf_data_i;
						nxt_state = csi_pkg::S_BUS;
					end else begin
						nxt_refused = 1'b1; // [RL4]
					end
				end
			end
			csi_pkg::S_CAPT: begin
				nxt_saved = ctl_ff; // [RL5]
				nxt_ctl = (ctl_ff | csi_pkg::CTL_MASKS) & ~csi_pkg::CTL_ALLOW; // [RL5]
				nxt_acc = status; // [RL9]
				if (interrupt_line_s_ff) begin // [RL7]
					nxt_vchk = 1'b1;
					nxt_state = csi_pkg::S_VEC;
				end else begin
					nxt_state = csi_pkg::S_FETCH;
				end
			end
			csi_pkg::S_FETCH: begin
				if (limit_ff != csi_pkg::ZERO16 && count_ff == limit_ff) begin // [RL11] [RL12]
					nxt_err = 1'b1;
					nxt_state = csi_pkg::S_FINISH;
				end else begin
					nxt_count = count_ff + 16'h0001; // [RL11]
					nxt_state = csi_pkg::S_DECODE;
				end
			end
			csi_pkg::S_DECODE: begin
				nxt_ip = ip_ff + 1'b1; // [RL10]
				nxt_state = csi_pkg::S_FETCH;
				nxt_rd = 1'b0;
				nxt_bsel = 1'b0;
				nxt_wr_pend = 1'b0;
				if (ins.opc[15:4] != csi_pkg::OPC_HI_ZERO) begin
					nxt_err = 1'b1; // [RL24]
					nxt_state = csi_pkg::S_FINISH;
				end else begin
					unique case (csi_pkg::csi_opc_t'(ins.opc[3:0]))
						csi_pkg::OP_END: begin
							nxt_state = csi_pkg::S_FINISH; // [RL13]
						end
						csi_pkg::OP_WRITE_CONTROL: begin
							nxt_shadow = ins.op2; // [RL6] [RL13]
							nxt_shadow_vld = 1'b1;
						end
						csi_pkg::OP_READ_STATUS: begin
							nxt_acc = status; // [RL9] [RL13]
							nxt_addr = ins.op2;
							nxt_wdata = status;
							nxt_state = csi_pkg::S_BUS;
						end
						csi_pkg::OP_WRITE_IMMEDIATE_WORD: begin
							nxt_addr = ins.op1; // [RL14]
							nxt_wdata = ins.op2;
							nxt_state = csi_pkg::S_BUS;
						end
						csi_pkg::OP_WRITE_IMMEDIATE_BYTE: begin
							nxt_addr = ins.op1; // [RL14]
							nxt_wdata = {8'h00, ins.op2[7:0]};
							nxt_bsel = 1'b1;
							nxt_state = csi_pkg::S_BUS;
						end
						csi_pkg::OP_MOVE, csi_pkg::OP_LOAD: begin
							nxt_addr = ins.op1; // [RL15]
							nxt_tgt = ins.op2;
							nxt_rd = 1'b1;
							nxt_wr_pend = (ins.opc[3:0] == csi_pkg::OP_MOVE);
							nxt_state = csi_pkg::S_BUS;
						end
						csi_pkg::OP_BRANCH_IF_MASKED_ZERO: begin
							if (masked == csi_pkg::ZERO16) begin // [RL16]
								nxt_ip = ins.op1[csi_pkg::IP_W-1:0];
							end
						end
						csi_pkg::OP_BRANCH_IF_ALL_MASKED_SET: begin
							if (masked == ins.op2) begin // [RL17]
								nxt_ip = ins.op1[csi_pkg::IP_W-1:0];
							end
						end
						csi_pkg::OP_JUMP: begin
							nxt_ip = ins.op1[csi_pkg::IP_W-1:0]; // [RL18]
						end
						csi_pkg::OP_BRANCH_IF_EQUAL: begin
							if (acc_ff == ins.op2) begin // [RL18]
								nxt_ip = ins.op1[csi_pkg::IP_W-1:0];
							end
						end
						csi_pkg::OP_READ_VECTOR: begin
							nxt_vchk = 1'b0; // [RL19]
							nxt_tgt = ins.op2;
							nxt_state = csi_pkg::S_VEC;
						end
						csi_pkg::OP_SET_LIMIT: begin
							nxt_limit = ins.op2; // [RL12]
						end
						csi_pkg::OP_WRITE_WIDTH_MODE: begin
							nxt_word_mode = ins.op1[0]; // [RL20]
						end
						csi_pkg::OP_HOST_ATTENTION: begin
							nxt_attn = 1'b1; // [RL21]
							nxt_attn_data = ins.op1;
						end
						csi_pkg::OP_UNDEFINED: begin
							nxt_err = 1'b1; // [RL24]
							nxt_state = csi_pkg::S_FINISH;
						end
					endcase
				end
			end
			csi_pkg::S_BUS: begin
				// Nothing reaches the bus while an interrupt stands.
				if (!interrupt_line_s_ff) begin // [RL2]
					nxt_pio.req = 1'b1;
					nxt_pio.we = !rd_ff;
					nxt_pio.bsel = bsel_ff;
					nxt_pio.addr = addr_ff;
					if (word_mode_ff || bsel_ff || host_ff) begin
						nxt_pio.wdata = wdata_ff;
					end else begin
						nxt_pio.wdata = {wdata_ff[7:0], wdata_ff[15:8]}; // [RL20]
					end
					nxt_state = csi_pkg::S_ACK;
				end
			end
			csi_pkg::S_ACK: begin
				if (done_ff) begin
					// Reading the read-data register retires the access.
					nxt_done = 1'b0; // [RL1]
					if (rd_ff) begin
						nxt_acc = pio_rdata_i; // [RL9] [RL15]
					end
					if (host_ff) begin
						nxt_host = 1'b0;
						nxt_state = csi_pkg::S_IDLE;
					end else if (wr_pend_ff) begin
						nxt_wr_pend = 1'b0;
						nxt_rd = 1'b0;
						nxt_addr = tgt_ff;
						nxt_wdata = pio_rdata_i; // [RL15]
						nxt_state = csi_pkg::S_BUS;
					end else begin
						nxt_state = csi_pkg::S_FETCH;
					end
				end
				if (pio_done_i) begin
					nxt_done = 1'b1; // [RL1]
				end
			end
			csi_pkg::S_VEC: begin
				nxt_vec_rd = 1'b1; // [RL23]
				nxt_state = csi_pkg::S_VWAIT;
			end
			csi_pkg::S_VWAIT: begin
				if (vec_ack_i) begin
					nxt_acc = vec_data_i; // [RL9] [RL19]
					if (vchk_ff) begin
						nxt_vchk = 1'b0;
						nxt_state = csi_pkg::S_FETCH; // [RL7]
					end else begin
						nxt_rd = 1'b0;
						nxt_addr = tgt_ff;
						nxt_wdata = vec_data_i; // [RL19]
						nxt_state = csi_pkg::S_BUS;
					end
				end
			end
			csi_pkg::S_FINISH: begin
				nxt_ctl = shadow_vld_ff ? shadow_ff : saved_ff; // [RL6]
				nxt_dev_end = 1'b1; // [RL8]
				nxt_uc = err_ff; // [RL11]
				nxt_lerr = err_ff; // [RL11]
				if (interrupt_line_s_ff) begin
					nxt_attn = 1'b1; // [RL8]
					nxt_attn_data = csi_pkg::INTERRUPT_LINE_ATTN_DATA;
				end
				nxt_state = csi_pkg::S_IDLE;
			end
			default: begin
				nxt_state = csi_pkg::S_IDLE;
			end
		endcase
		nxt_busy = (nxt_state != csi_pkg::S_IDLE);
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= csi_pkg::S_IDLE;
			pio_ff <= '0;
			ip_ff <= '0;
			count_ff <= csi_pkg::ZERO16;
			limit_ff <= csi_pkg::LIMIT_RST;
			acc_ff <= csi_pkg::ZERO16;
			ctl_ff <= csi_pkg::CTL_RST;
			saved_ff <= csi_pkg::CTL_RST;
			shadow_ff <= csi_pkg::CTL_RST;
			shadow_vld_ff <= 1'b0;
			word_mode_ff <= 1'b1;
			err_ff <= 1'b0;
			done_ff <= 1'b0;
			rd_ff <= 1'b0;
			bsel_ff <= 1'b0;
			wr_pend_ff <= 1'b0;
			host_ff <= 1'b0;
			vchk_ff <= 1'b0;
			addr_ff <= csi_pkg::ZERO16;
			wdata_ff <= csi_pkg::ZERO16;
			tgt_ff <= csi_pkg::ZERO16;
			stat_ff <= csi_pkg::ZERO16;
			vec_rd_ff <= 1'b0;
			refused_ff <= 1'b0;
			dev_end_ff <= 1'b0;
			uc_ff <= 1'b0;
			attn_ff <= 1'b0;
			attn_data_ff <= csi_pkg::ZERO16;
			lerr_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			pio_ff <= nxt_pio;
			ip_ff <= nxt_ip;
			count_ff <= nxt_count;
			limit_ff <= nxt_limit;
			acc_ff <= nxt_acc;
			ctl_ff <= nxt_ctl;
			saved_ff <= nxt_saved;
			shadow_ff <= nxt_shadow;
			shadow_vld_ff <= nxt_shadow_vld;
			word_mode_ff <= nxt_word_mode;
			err_ff <= nxt_err;
			done_ff <= nxt_done;
			rd_ff <= nxt_rd;
			bsel_ff <= nxt_bsel;
			wr_pend_ff <= nxt_wr_pend;
			host_ff <= nxt_host;
			vchk_ff <= nxt_vchk;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			tgt_ff <= nxt_tgt;
			stat_ff <= status;
			vec_rd_ff <= nxt_vec_rd;
			refused_ff <= nxt_refused;
			dev_end_ff <= nxt_dev_end;
			uc_ff <= nxt_uc;
			attn_ff <= nxt_attn;
			attn_data_ff <= nxt_attn_data;
			lerr_ff <= nxt_lerr;
			busy_ff <= nxt_busy;
		end
	end

	assign pio_o = pio_ff;
	assign vec_rd_o = vec_rd_ff;
	assign adapter_control_o = ctl_ff;
	assign adapter_status_o = stat_ff;
	assign accumulator_o = acc_ff;
	assign busy_o = busy_ff;
	assign buf_refused_o = refused_ff;
	assign dev_end_o = dev_end_ff;
	assign unit_check_o = uc_ff;
	assign attn_o = attn_ff;
	assign attn_data_o = attn_data_ff;
	assign local_err_o = lerr_ff;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_done_sets: assert property ( // [RL1]
		(state_ff == csi_pkg::S_ACK && pio_done_i) |=> done_ff)
		else $error("transfer done flag not set");
	a_done_clears: assert property ( // [RL1]
		(state_ff == csi_pkg::S_ACK && done_ff && !pio_done_i) |=> !done_ff)
		else $error("transfer done flag not cleared");
	a_interrupt_line_blocks: assert property ( // [RL2]
		(state_ff == csi_pkg::S_BUS && interrupt_line_s_ff) |=> !pio_ff.req)
		else $error("bus access issued under interrupt");
	a_status_mirror: assert property ( // [RL3]
		##1 stat_ff[6:0] == $past(ctl_ff[6:0]))
		else $error("status does not mirror control");
	a_buf_range: assert property ( // [RL4]
		(pio_ff.req && host_ff) |-> pio_ff.addr <= csi_pkg::BUF_TOP)
		else $error("host write outside buffer");
	a_masks_held: assert property ( // [RL5]
		(state_ff == csi_pkg::S_DECODE) |->
		((ctl_ff & csi_pkg::CTL_MASKS) == csi_pkg::CTL_MASKS &&
		(ctl_ff & csi_pkg::CTL_ALLOW) == csi_pkg::ZERO16))
		else $error("masks not held while interpreting");
	a_ctl_restore: assert property ( // [RL6]
		dev_end_ff |-> ctl_ff ==
		($past(shadow_vld_ff) ? $past(shadow_ff) : $past(saved_ff)))
		else $error("control not restored at end");
	a_limit_stop: assert property ( // [RL11]
		(state_ff == csi_pkg::S_FETCH && limit_ff != csi_pkg::ZERO16 &&
		count_ff == limit_ff) |=> ##1 (dev_end_ff && uc_ff))
		else $error("limit did not stop the program");
	a_ip_zero: assert property ( // [RL10]
		(state_ff == csi_pkg::S_IDLE && start_i &&
		start_addr_i[31:16] != csi_pkg::START_KEY) |=> ip_ff == '0)
		else $error("pointer not zeroed on entry");
	c_dev_end: cover property (dev_end_ff && !uc_ff);
	c_unit_check: cover property (dev_end_ff && uc_ff);
	c_attention: cover property (attn_ff);
	c_vec_read: cover property (vec_rd_ff);
endmodule : csi_interp
`default_nettype wire

// file: test/csi_periph_model.sv
// Purpose: Far-side model of the peripheral bus and its interrupt source.
// Assumes: Requests arrive as one-cycle pulses on the system clock.
// Notes: Answers after a delay the bench chooses; released data toggles.
`timescale 1ns/1ps
`default_nettype none
module csi_periph_model #(
	parameter logic [15:0] VEC = 16'h0154
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire csi_pkg::csi_pio_t pio_i,
	input wire logic [2:0] delay_i,
	input wire logic raise_i,
	output logic pio_done_o,
	output logic [15:0] pio_rdata_o,
	input wire logic vec_rd_i,
	output logic vec_ack_o,
	output logic [15:0] vec_data_o,
	output logic interrupt_line_o
);
	logic [15:0] mem [0:255];
	csi_pkg::csi_pio_t cur;
	logic pio_busy, vec_busy;
	int pio_cnt, vec_cnt, hold;

	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pio_done_o <= 1'b0;
			vec_ack_o <= 1'b0;
			interrupt_line_o <= 1'b0;
			pio_busy <= 1'b0;
			vec_busy <= 1'b0;
			hold <= 0;
			pio_rdata_o <= 16'h5A5A;
			vec_data_o <= 16'hA5A5;
		end else begin
			pio_done_o <= 1'b0;
			vec_ack_o <= 1'b0;
			if (raise_i) begin
				interrupt_line_o <= 1'b1;
			end
			if (pio_i.req) begin
				cur <= pio_i;
				pio_busy <= 1'b1;
				pio_cnt <= delay_i;
			end else if (pio_busy && pio_cnt > 0) begin
				pio_cnt <= pio_cnt - 1;
			end else if (pio_busy) begin
				pio_busy <= 1'b0;
				pio_done_o <= 1'b1;
				hold <= 3;
				pio_rdata_o <= mem[cur.addr[7:0]];
				if (cur.we && cur.bsel) begin
					mem[cur.addr[7:0]][7:0] <= cur.wdata[7:0];
				end else if (cur.we) begin
					mem[cur.addr[7:0]] <= cur.wdata;
				end
			end else if (hold > 0) begin
				hold <= hold - 1;
			end else begin
				pio_rdata_o <= ~pio_rdata_o;
			end
			if (vec_rd_i) begin
				vec_busy <= 1'b1;
				vec_cnt <= delay_i;
			end else if (vec_busy && vec_cnt > 0) begin
				vec_cnt <= vec_cnt - 1;
			end else if (vec_busy) begin
				// Handing over the vector also drops the pending request.
				vec_busy <= 1'b0;
				vec_ack_o <= 1'b1;
				vec_data_o <= VEC;
				interrupt_line_o <= 1'b0;
			end else begin
				vec_data_o <= ~vec_data_o;
			end
		end
	end
endmodule : csi_periph_model
`default_nettype wire

// file: test/csi_interp_tb.sv
// Purpose: Self-checking bench of the control space interpreter.
// Assumes: Inputs change on the falling clock edge.
// Notes: Drivers queue expected events; a monitor pops and compares them.
`timescale 1ns/1ps
`default_nettype none
module csi_interp_tb;
	typedef struct packed {
		logic [15:0] mask;
		logic bsel;
		logic [15:0] addr;
		logic [15:0] data;
	} csi_wr_t;
	typedef struct packed {
		logic uc;
		logic err;
		logic [15:0] acc;
		logic [15:0] ctl;
	} csi_end_t;
	logic sys_clk_i = 1'b0, rst_n_i = 1'b0, prog_wr_i = 1'b0, raise = 1'b0;
	logic buf_wr_i = 1'b0, start_i = 1'b0;
	logic [5:0] prog_addr_i = 6'h00;
	csi_pkg::csi_instr_t prog_data_i = '0;
	logic [15:0] buf_addr_i = 16'h0000, buf_data_i = 16'h0000, b, r;
	logic [31:0] start_addr_i = 32'h00000000, lfsr = 32'h00015F62;
	logic [2:0] dly = 3'h0;
	csi_pkg::csi_pio_t pio;
	logic pio_done, vec_rd, vec_ack, interrupt_line, busy, refused, dev_end, uc, attn, err;
	logic [15:0] pio_rdata, vec_data, ctl, status, acc, attn_data;
	int bad_count = 0, checks = 0, ends = 0, exp_ref = 0;
	csi_wr_t exp_wr[$];
	csi_end_t exp_end[$];
	logic [15:0] exp_attn[$];
	csi_wr_t w;
	logic [1:0] dq = 2'b00;
	localparam logic [15:0] VEC = 16'h0154;

	csi_interp DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.prog_wr_i(prog_wr_i), .prog_addr_i(prog_addr_i),
		.prog_data_i(prog_data_i), .buf_wr_i(buf_wr_i),
		.buf_addr_i(buf_addr_i), .buf_data_i(buf_data_i), .start_i(start_i),
		.start_addr_i(start_addr_i), .pio_o(pio), .pio_done_i(pio_done),
		.pio_rdata_i(pio_rdata), .interrupt_line_i(interrupt_line), .vec_rd_o(vec_rd),
		.vec_ack_i(vec_ack), .vec_data_i(vec_data), .adapter_control_o(ctl),
		.adapter_status_o(status), .accumulator_o(acc), .busy_o(busy),
		.buf_refused_o(refused), .dev_end_o(dev_end), .unit_check_o(uc),
		.attn_o(attn), .attn_data_o(attn_data), .local_err_o(err));
	csi_periph_model #(.VEC(VEC)) partner (.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i), .pio_i(pio), .delay_i(dly), .raise_i(raise),
		.pio_done_o(pio_done), .pio_rdata_o(pio_rdata), .vec_rd_i(vec_rd),
		.vec_ack_o(vec_ack), .vec_data_o(vec_data), .interrupt_line_o(interrupt_line));

	always #5 sys_clk_i = ~sys_clk_i;

	function automatic logic [31:0] rnd(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : rnd

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
		input string what);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude

	task automatic ins(input int i, input logic [15:0] o, a, c);
		@(negedge sys_clk_i);
		prog_wr_i = 1'b1;
		prog_addr_i = i[5:0];
		prog_data_i = {o, a, c};
	endtask : ins

	task automatic run(input logic [31:0] sa, input csi_end_t e, input logic irq);
		int n;
		n = ends;
		exp_end.push_back(e);
		@(negedge sys_clk_i);
		prog_wr_i = 1'b0;
		lfsr = rnd(lfsr);
		dly = lfsr[2:0];
		start_addr_i = sa;
		start_i = 1'b1;
		raise = irq;
		@(negedge sys_clk_i);
		start_i = 1'b0;
		raise = 1'b0;
		for (int k = 0; k < 3000 && ends == n; k++) @(negedge sys_clk_i);
		if (ends == n) chk(64'h0, 64'h1, "no device end");
		repeat (2) @(negedge sys_clk_i);
	endtask : run

	always @(posedge sys_clk_i) begin
		if (rst_n_i && pio.req && pio.we) begin
			w = (exp_wr.size() > 0) ? exp_wr.pop_front() : '1;
			chk({pio.bsel, pio.addr, pio.wdata & w.mask},
				{w.bsel, w.addr, w.data & w.mask}, "bus write");
		end
		if (rst_n_i && attn) begin
			if (exp_attn.size() == 0) chk(64'h0, 64'h1, "stray attention");
			else chk(attn_data, exp_attn.pop_front(), "attention data");
		end
		if (rst_n_i && dev_end) begin
			if (exp_end.size() == 0) chk(64'h0, 64'h1, "stray end");
			else chk({uc, err, acc, ctl}, exp_end.pop_front(), "end state");
			ends++;
		end
		if (rst_n_i && refused) begin
			chk(64'(exp_ref), 64'h1, "refusal");
			exp_ref--;
		end
		if (rst_n_i && (dq[1] || status[10])) begin
			chk(status[10], dq[1], "done flag");
		end
		dq <= {dq[0], pio_done};
	end

	initial begin
		#400000;
		bad_count++;
		$display("unexpected at %0t: watchdog expired", $time);
		conclude();
	end

	initial begin
		repeat (8) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		rst_n_i = 1'b1;
		chk({status, acc, ctl}, 64'h0, "reset values");
		b = lfsr[15:0];
		lfsr = rnd(lfsr);
		r = lfsr[15:0];
		ins(0, 16'h0003, 16'h0010, 16'hA5C3);
		ins(1, 16'h0004, 16'h0010, 16'h0011);
		ins(2, 16'h0005, 16'h0004, 16'h0004);
		ins(3, 16'h000E, 16'hDEAD, 16'h0000);
		ins(4, 16'h0006, 16'h0006, 16'h00C3);
		ins(5, 16'h000E, 16'hBAD0, 16'h0000);
		ins(6, 16'h0009, 16'h0008, 16'hA5C3);
		ins(7, 16'h000E, 16'h1111, 16'h0000);
		ins(8, 16'h0001, 16'h0000, 16'h0055);
		ins(9, 16'h000B, 16'h0020, b);
		ins(10, 16'h000C, 16'h0010, 16'h0000);
		ins(11, 16'h0002, 16'h0000, 16'h0030);
		ins(12, 16'h000E, 16'h0E0E, 16'h0000);
		ins(13, 16'h000D, 16'h0000, 16'h0000);
		ins(14, 16'h0003, 16'h0040, r);
		ins(15, 16'h0007, 16'h0011, 16'h0000);
		ins(16, 16'h000E, 16'h2222, 16'h0000);
		ins(17, 16'h0000, 16'h0000, 16'h0000);
		exp_wr.push_back({16'hFFFF, 1'b0, 16'h0010, 16'hA5C3});
		exp_wr.push_back({16'hFFFF, 1'b0, 16'h0011, 16'hA5C3});
		exp_wr.push_back({16'h00FF, 1'b1, 16'h0020, b});
		exp_wr.push_back({16'hFFFF, 1'b0, 16'h0030, 16'h003E});
		exp_attn.push_back(16'h0E0E);
		exp_wr.push_back({16'hFFFF, 1'b0, 16'h0040, r[7:0], r[15:8]});
		run(32'h00000000, {1'b0, 1'b0, 16'h003E, 16'h0055}, 1'b0);
		ins(48, 16'h000D, 16'h0001, 16'h0000);
		ins(49, 16'h0007, 16'h0032, 16'h0000);
		ins(50, 16'h0007, 16'h0033, 16'h0000);
		ins(51, 16'h0000, 16'h0000, 16'h0000);
		exp_attn.push_back(16'h0000);
		run(32'hFFFF0030, {1'b0, 1'b0, 16'h0055, 16'h0055}, 1'b1);
		chk(status, 16'h00D5, "interrupt flag");
		ins(52, 16'h0003, 16'h0053, 16'h7777);
		ins(53, 16'h0008, 16'h0000, 16'h0054);
		ins(54, 16'h0000, 16'h0000, 16'h0000);
		exp_wr.push_back({16'hFFFF, 1'b0, 16'h0053, 16'h7777});
		exp_wr.push_back({16'hFFFF, 1'b0, 16'h0054, VEC});
		run(32'hFFFF0034, {1'b0, 1'b0, VEC, 16'h0055}, 1'b0);
		repeat (6) @(negedge sys_clk_i);
		chk(status, 16'h0055, "interrupt cleared");
		ins(30, 16'h000A, 16'h0000, 16'h0003);
		ins(31, 16'h0007, 16'h001F, 16'h0000);
		run(32'hFFFF001E, {1'b1, 1'b1, 16'h0055, 16'h0055}, 1'b0);
		ins(40, 16'h000A, 16'h0000, 16'h0000);
		ins(41, 16'h0009, 16'h003F, 16'h0000);
		ins(42, 16'h0005, 16'h003F, 16'hFFFF);
		ins(43, 16'h0006, 16'h003F, 16'hFFFF);
		ins(44, 16'h0007, 16'h002E, 16'h0000);
		ins(45, 16'h000E, 16'hBAD0, 16'h0000);
		ins(46, 16'h0000, 16'h0000, 16'h0000);
		ins(62, 16'h0100, 16'h0000, 16'h0000);
		ins(63, 16'h000F, 16'h0000, 16'h0000);
		run(32'hFFFF0028, {1'b0, 1'b0, 16'h0055, 16'h0055}, 1'b0);
		for (int i = 62; i < 64; i++) begin
			run({16'hFFFF, 10'h000, i[5:0]}, {1'b1, 1'b1, 16'h0055, 16'h0055}, 1'b0);
		end
		lfsr = rnd(lfsr);
		exp_wr.push_back({16'hFFFF, 1'b0, 16'hDFFF, lfsr[15:0]});
		@(negedge sys_clk_i);
		buf_wr_i = 1'b1;
		buf_addr_i = 16'hDFFF;
		buf_data_i = lfsr[15:0];
		@(negedge sys_clk_i);
		buf_wr_i = 1'b0;
		for (int k = 0; k < 40 && busy !== 1'b0; k++) @(negedge sys_clk_i);
		exp_ref = 1;
		buf_wr_i = 1'b1;
		buf_addr_i = 16'hE000;
		@(negedge sys_clk_i);
		buf_wr_i = 1'b0;
		repeat (10) @(negedge sys_clk_i);
		chk(64'(exp_ref), 64'h0, "refusal seen");
		chk(64'(exp_wr.size() + exp_attn.size() + exp_end.size()), 64'h0,
			"missing events");
		conclude();
	end
endmodule : csi_interp_tb
`default_nettype wire
